// ===== hw/servo_pulse_io.sv
// Command pulse decoder, settle flag, torque caps and encoder pulse output
// What this block does
// - Settled flag when error within range, default 100
// - Option selects range unit: encoder output pulses
// - Forward cap limits CCW drive, CW regeneration
// - Reverse cap limits CW drive, CCW regeneration
// - Cap of zero gives no torque
// - Monitor full scale equals smaller cap
// - Form digit: two trains, pulse-sign, quadrature
// - Second digit one inverts command input logic
// - Quadrature counts every edge, four per cycle
// - Boot settings apply only after restart
// - Direction setting one swaps rotation sense
// - Output count 1 to 100000, default 4000
// - A/B cycles are quarter of count
// - Encoder output edges limited to 4.6 Mpps
// - Mode 0: count edges per revolution
// - Mode 1: resolution divided by count
// - Mode 2: feedback in command pulse unit
//
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "servo_io_regs.svh"
module servo_pulse_io
	import servo_io_pkg::*;
#(
	parameter int unsigned ENC_RES = 262144,
	parameter int unsigned PEND_W = 8
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Command pulse pins
	input wire logic forward_pulse_line,
	input wire logic reverse_pulse_line,
	// Decoded command to the position loop
	output motion_t cmd_out,
	// Motor encoder feedback, one pulse per count
	input wire logic fb_step,
	input wire logic fb_ccw,
	// Position error, command and encoder output units
	input wire logic signed [31:0] pos_err_cmd,
	input wire logic signed [31:0] pos_err_enc,
	output logic position_settled_flag,
	// Torque, 0.1 percent units, positive is CCW
	input wire logic signed [15:0] torque_req,
	output logic signed [15:0] torque_out,
	output logic [15:0] monitor_full_scale,
	// Encoder pulse output
	output logic enc_out_a,
	output logic enc_out_b,
	// Interrupt
	output logic irq
);
	localparam logic [6:0] GAP = 7'(`ENC_GAP_CYC);

	// Parameter checks
	if (ENC_RES < 1 || ENC_RES > 32'h00ffffff)
		$error("ENC_RES out of range");
	if (PEND_W < 2 || PEND_W > 16)
		$error("PEND_W out of range");

	function automatic logic [31:0] abs32(input logic signed [31:0] v);
		abs32 = v[31] ? 32'(-v) : 32'(v);
	endfunction : abs32

	function automatic logic [1:0] quad_idx(input logic a, input logic b);
		quad_idx = {b, a ^ b};
	endfunction : quad_idx

	function automatic logic [16:0] clamp_count(input logic [31:0] v);
		if (v == 32'h0)
			clamp_count = `ENC_COUNT_MIN;
		else if (v > {15'h0, `ENC_COUNT_MAX})
			clamp_count = `ENC_COUNT_MAX;
		else
			clamp_count = v[16:0];
	endfunction : clamp_count

	function automatic logic [15:0] clamp_cap(input logic [31:0] v);
		clamp_cap = (v > {16'h0, `RST_CAP}) ? `RST_CAP : v[15:0];
	endfunction : clamp_cap

	logic [15:0] settle_range_reg;
	logic [15:0] fwd_cap_reg;
	logic [15:0] rev_cap_reg;
	logic [15:0] form_reg;
	logic sense_reg;
	logic [16:0] enc_count_reg;
	logic [15:0] enc_mode_reg;
	logic settle_unit_reg;
	logic [16:0] cmd_rev_reg;
	logic [`IRQ_W-1:0] irq_st_reg;
	logic [`IRQ_W-1:0] irq_mask_reg;
	boot_cfg_t pend_cfg;
	boot_cfg_t act_reg;
	logic restart;
	logic wr_hit;

	assign wr_hit = reg_wr;
	assign restart = reg_wr && reg_addr == `OFS_RESTART && reg_wdata[0];

	// Software writable settings
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			settle_range_reg <= `RST_SETTLE_RANGE;
			fwd_cap_reg <= `RST_CAP;
			rev_cap_reg <= `RST_CAP;
			form_reg <= `RST_INPUT_FORM;
			sense_reg <= `RST_ROT_SENSE;
			enc_count_reg <= `RST_ENC_COUNT;
			enc_mode_reg <= `RST_ENC_MODE;
			settle_unit_reg <= 1'b0;
			cmd_rev_reg <= `RST_ENC_COUNT;
			irq_mask_reg <= '0;
		end else if (wr_hit) begin
			case (reg_addr)
				`OFS_SETTLE_RANGE: settle_range_reg <= reg_wdata[15:0];
				`OFS_FWD_CAP: fwd_cap_reg <= clamp_cap(reg_wdata);
				`OFS_REV_CAP: rev_cap_reg <= clamp_cap(reg_wdata);
				`OFS_INPUT_FORM: form_reg <= reg_wdata[15:0];
				`OFS_ROT_SENSE: sense_reg <= reg_wdata[0];
				`OFS_ENC_COUNT: enc_count_reg <= clamp_count(reg_wdata);
				`OFS_ENC_MODE: enc_mode_reg <= reg_wdata[15:0];
				`OFS_SETTLE_UNIT: settle_unit_reg <= reg_wdata[0];
				`OFS_CMD_PER_REV: cmd_rev_reg <= clamp_count(reg_wdata);
				`OFS_IRQ_MASK: irq_mask_reg <= reg_wdata[`IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	// Decode stored settings into the boot image
	always_comb begin
		pend_cfg.neg = form_reg[`FORM_NEG_BIT];
		case (form_reg[3:0])
			4'h0: pend_cfg.form = FORM_TWO_TRAIN;
			4'h1: pend_cfg.form = FORM_PULSE_SIGN;
			4'h2: pend_cfg.form = FORM_QUAD;
			default: pend_cfg.form = FORM_NONE;
		endcase
		pend_cfg.sense = sense_reg;
		pend_cfg.enc_count = enc_count_reg;
		case (enc_mode_reg[`ENC_MODE_LSB +: 4])
			4'h0: pend_cfg.out_mode = OUT_COUNT;
			4'h1: pend_cfg.out_mode = OUT_DIVIDE;
			4'h2: pend_cfg.out_mode = OUT_CMD_UNIT;
			default: pend_cfg.out_mode = OUT_OFF;
		endcase
		pend_cfg.cmd_per_rev = cmd_rev_reg;
	end

	// Boot settings take the stored values only on restart
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			act_reg <= '{FORM_TWO_TRAIN, 1'b0, `RST_ROT_SENSE,
				`RST_ENC_COUNT, OUT_COUNT, `RST_ENC_COUNT};
		end else if (restart) begin
			act_reg <= pend_cfg;
		end
	end

	// Command input polarity and edge history
	logic pp_lvl;
	logic np_lvl;
	logic pp_prev_reg;
	logic np_prev_reg;
	logic primed_reg;
	assign pp_lvl = forward_pulse_line ^ act_reg.neg;
	assign np_lvl = reverse_pulse_line ^ act_reg.neg;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pp_prev_reg <= 1'b0;
			np_prev_reg <= 1'b0;
			primed_reg <= 1'b0;
		end else begin
			pp_prev_reg <= pp_lvl;
			np_prev_reg <= np_lvl;
			primed_reg <= !restart;
		end
	end

	// Step and direction from the selected form
	logic step_c;
	logic fwd_c;
	logic [1:0] qd;
	always_comb begin
		step_c = 1'b0;
		fwd_c = 1'b1;
		qd = quad_idx(pp_lvl, np_lvl) - quad_idx(pp_prev_reg, np_prev_reg);
		case (act_reg.form)
			FORM_TWO_TRAIN: begin
				step_c = (pp_lvl && !pp_prev_reg) ^ (np_lvl && !np_prev_reg);
				fwd_c = pp_lvl && !pp_prev_reg;
			end
			FORM_PULSE_SIGN: begin
				step_c = pp_lvl && !pp_prev_reg;
				fwd_c = !np_lvl;
			end
			FORM_QUAD: begin
				step_c = qd == 2'h1 || qd == 2'h3;
				fwd_c = qd == 2'h1;
			end
			default: ;
		endcase
		if (!primed_reg)
			step_c = 1'b0;
	end

	// Registered command with rotation sense applied
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_out <= '0;
		end else begin
			cmd_out.step <= step_c;
			cmd_out.ccw <= fwd_c ^ act_reg.sense;
		end
	end

	// Settled flag from absolute error
	logic [31:0] err_abs;
	assign err_abs = abs32(settle_unit_reg ? pos_err_enc : pos_err_cmd);
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			position_settled_flag <= 1'b0;
		else
			position_settled_flag <= err_abs <= {16'h0, settle_range_reg};
	end

	// Torque caps per torque sign
	logic signed [16:0] rev_neg;
	logic over_fwd;
	logic over_rev;
	assign rev_neg = -$signed({1'b0, rev_cap_reg});
	assign over_fwd = $signed({torque_req[15], torque_req}) >
		$signed({1'b0, fwd_cap_reg});
	assign over_rev = $signed({torque_req[15], torque_req}) < rev_neg;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			torque_out <= '0;
			monitor_full_scale <= `RST_CAP;
		end else begin
			if (over_fwd)
				torque_out <= $signed(fwd_cap_reg);
			else if (over_rev)
				torque_out <= rev_neg[15:0];
			else
				torque_out <= torque_req;
			monitor_full_scale <= (fwd_cap_reg < rev_cap_reg) ?
				fwd_cap_reg : rev_cap_reg;
		end
	end

	// Feedback to output edge conversion
	logic [31:0] acc_reg;
	logic [16:0] div_reg;
	logic [31:0] acc_sum;
	logic [16:0] dda_add;
	logic edge_req;
	assign dda_add = act_reg.out_mode == OUT_CMD_UNIT ?
		act_reg.cmd_per_rev : act_reg.enc_count;
	assign acc_sum = acc_reg + {15'h0, dda_add};
	always_comb begin
		case (act_reg.out_mode)
			OUT_COUNT, OUT_CMD_UNIT: edge_req = fb_step && acc_sum >= ENC_RES;
			OUT_DIVIDE: edge_req = fb_step &&
				div_reg + 17'h1 >= act_reg.enc_count;
			default: edge_req = 1'b0;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_reg <= '0;
			div_reg <= '0;
		end else if (restart) begin
			acc_reg <= '0;
			div_reg <= '0;
		end else if (fb_step) begin
			acc_reg <= edge_req ? acc_sum - ENC_RES : acc_sum;
			div_reg <= edge_req ? 17'h0 : div_reg + 17'h1;
		end
	end

	// Pending edges paced to the output rate limit
	logic signed [PEND_W-1:0] pend_reg;
	logic [6:0] gap_reg;
	logic [1:0] q_reg;
	logic emit;
	logic signed [PEND_W-1:0] pend_in;
	logic overrun;
	localparam logic signed [PEND_W-1:0] PMAX = {1'b0, {(PEND_W-1){1'b1}}};
	assign emit = pend_reg != '0 && gap_reg == '0;
	assign overrun = edge_req && (fb_ccw ? pend_reg == -PMAX : pend_reg == PMAX);
	always_comb begin
		pend_in = pend_reg;
		if (emit)
			pend_in = pend_reg[PEND_W-1] ? pend_reg + 1'b1 : pend_reg - 1'b1;
		if (edge_req && !overrun)
			pend_in = fb_ccw ? pend_in - 1'b1 : pend_in + 1'b1;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pend_reg <= '0;
			gap_reg <= '0;
			q_reg <= '0;
		end else if (restart) begin
			// Pacing keeps counting so a restart cannot shorten an edge gap
			pend_reg <= '0;
			if (gap_reg != '0)
				gap_reg <= gap_reg - 7'h1;
		end else begin
			pend_reg <= pend_in;
			if (emit) begin
				gap_reg <= GAP - 7'h1;
				q_reg <= pend_reg[PEND_W-1] ? q_reg - 2'h1 : q_reg + 2'h1;
			end else if (gap_reg != '0) begin
				gap_reg <= gap_reg - 7'h1;
			end
		end
	end

	// Quadrature phases, four edges per A/B cycle
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			enc_out_a <= 1'b0;
			enc_out_b <= 1'b0;
		end else begin
			enc_out_a <= q_reg[1] ^ q_reg[0];
			enc_out_b <= q_reg[1];
		end
	end

	// Sticky events, a set wins over a clear
	logic settled_d_reg;
	logic [`IRQ_W-1:0] ev;
	logic [`IRQ_W-1:0] clr;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			settled_d_reg <= 1'b0;
		else
			settled_d_reg <= position_settled_flag;
	end
	assign ev = {overrun, over_fwd || over_rev,
		position_settled_flag && !settled_d_reg};
	assign clr = (reg_wr && reg_addr == `OFS_IRQ_STATUS) ?
		reg_wdata[`IRQ_W-1:0] : '0;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			irq_st_reg <= '0;
		else
			irq_st_reg <= (irq_st_reg & ~clr) | ev;
	end
	assign irq = |(irq_st_reg & irq_mask_reg);

	// Read port, data in the cycle after the strobe
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= '0;
		end else if (!reg_rd) begin
			reg_rdata <= '0;
		end else begin
			case (reg_addr)
				`OFS_SETTLE_RANGE: reg_rdata <= {16'h0, settle_range_reg};
				`OFS_FWD_CAP: reg_rdata <= {16'h0, fwd_cap_reg};
				`OFS_REV_CAP: reg_rdata <= {16'h0, rev_cap_reg};
				`OFS_INPUT_FORM: reg_rdata <= {16'h0, form_reg};
				`OFS_ROT_SENSE: reg_rdata <= {31'h0, sense_reg};
				`OFS_ENC_COUNT: reg_rdata <= {15'h0, enc_count_reg};
				`OFS_ENC_MODE: reg_rdata <= {16'h0, enc_mode_reg};
				`OFS_SETTLE_UNIT: reg_rdata <= {31'h0, settle_unit_reg};
				`OFS_CMD_PER_REV: reg_rdata <= {15'h0, cmd_rev_reg};
				`OFS_STATUS: reg_rdata <= {22'h0, act_reg.out_mode,
					act_reg.form, act_reg.neg, act_reg.sense,
					enc_out_b, enc_out_a, position_settled_flag,
					pend_reg != '0};
				`OFS_IRQ_STATUS: reg_rdata <= {29'h0, irq_st_reg};
				`OFS_IRQ_MASK: reg_rdata <= {29'h0, irq_mask_reg};
				`OFS_MON_SCALE: reg_rdata <= {16'h0, monitor_full_scale};
				default: reg_rdata <= '0;
			endcase
		end
	end

	// Checks on the block's own behaviour
	logic [6:0] since_chg;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			since_chg <= 7'h7f;
		else if (enc_out_a != (q_reg[1] ^ q_reg[0]) || enc_out_b != q_reg[1])
			since_chg <= '0;
		else if (since_chg != 7'h7f)
			since_chg <= since_chg + 7'h1;
	end

	sequence restart_write_s;
		restart;
	endsequence

	settle_window_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(err_abs <= {16'h0, settle_range_reg}) |=> position_settled_flag)
		else $error("settled flag missing inside range");
	settle_out_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(err_abs > {16'h0, settle_range_reg}) |=> !position_settled_flag)
		else $error("settled flag outside range");
	fwd_cap_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		##1 $signed(torque_out) <= $signed({1'b0, $past(fwd_cap_reg)}))
		else $error("torque above forward cap");
	rev_cap_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		##1 $signed(torque_out) >= -$signed({1'b0, $past(rev_cap_reg)}))
		else $error("torque below reverse cap");
	zero_cap_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(fwd_cap_reg == 16'h0 && torque_req > 0) |=> torque_out == 16'sh0)
		else $error("torque with zero cap");
	mon_scale_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		##1 monitor_full_scale == (($past(fwd_cap_reg) < $past(rev_cap_reg))
		? $past(fwd_cap_reg) : $past(rev_cap_reg)))
		else $error("monitor scale not smaller cap");
	quad_edge_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(act_reg.form == FORM_QUAD && primed_reg && !restart &&
		(pp_lvl != pp_prev_reg) != (np_lvl != np_prev_reg)) |=> cmd_out.step)
		else $error("quadrature edge not counted");
	sense_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(act_reg.form == FORM_TWO_TRAIN && step_c && pp_lvl &&
		!pp_prev_reg) |=>
		cmd_out.ccw == !$past(act_reg.sense))
		else $error("rotation sense wrong");
	boot_load_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		restart_write_s |=> act_reg == $past(pend_cfg))
		else $error("boot settings not loaded on restart");
	boot_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!restart |=> $stable(act_reg))
		else $error("boot settings changed without restart");
	enc_rate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(emit && since_chg != 7'h7f) |-> since_chg >= GAP - 7'h2)
		else $error("encoder output too fast");
	irq_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(ev[`IRQ_SETTLE] && clr[`IRQ_SETTLE]) |=> irq_st_reg[`IRQ_SETTLE])
		else $error("event lost against clear");
endmodule : servo_pulse_io
`default_nettype wire

// ===== shared/servo_io_pkg.sv
// Types shared by the servo pulse IO logic
`default_nettype none
package servo_io_pkg;
	typedef enum logic [1:0] {
		FORM_TWO_TRAIN = 2'h0,
		FORM_PULSE_SIGN = 2'h1,
		FORM_QUAD = 2'h2,
		FORM_NONE = 2'h3
	} form_t;
	typedef enum logic [1:0] {
		OUT_COUNT = 2'h0,
		OUT_DIVIDE = 2'h1,
		OUT_CMD_UNIT = 2'h2,
		OUT_OFF = 2'h3
	} out_mode_t;
	typedef struct packed {
		form_t form;
		logic neg;
		logic sense;
		logic [16:0] enc_count;
		out_mode_t out_mode;
		logic [16:0] cmd_per_rev;
	} boot_cfg_t;
	typedef struct packed {
		logic step;
		logic ccw;
	} motion_t;
endpackage : servo_io_pkg
`default_nettype wire

// ===== shared/servo_io_regs.svh
// Register offsets, fields, reset values and timing of the servo pulse IO
`ifndef SERVO_IO_REGS_SVH
`define SERVO_IO_REGS_SVH
`define OFS_SETTLE_RANGE 8'h00
`define OFS_FWD_CAP 8'h04
`define OFS_REV_CAP 8'h08
`define OFS_INPUT_FORM 8'h0c
`define OFS_ROT_SENSE 8'h10
`define OFS_ENC_COUNT 8'h14
`define OFS_ENC_MODE 8'h18
`define OFS_SETTLE_UNIT 8'h1c
`define OFS_CMD_PER_REV 8'h20
`define OFS_RESTART 8'h24
`define OFS_STATUS 8'h28
`define OFS_IRQ_STATUS 8'h2c
`define OFS_IRQ_MASK 8'h30
`define OFS_MON_SCALE 8'h34
`define RST_SETTLE_RANGE 16'h0064
`define RST_CAP 16'h03e8
`define RST_INPUT_FORM 16'h0000
`define RST_ROT_SENSE 1'b0
`define RST_ENC_COUNT 17'h00fa0
`define RST_ENC_MODE 16'h0000
`define ENC_COUNT_MIN 17'h00001
`define ENC_COUNT_MAX 17'h186a0
`define FORM_NEG_BIT 4
`define ENC_MODE_LSB 4
`define IRQ_SETTLE 0
`define IRQ_CLAMP 1
`define IRQ_OVERRUN 2
`define IRQ_W 3
`define CLK_KHZ 250000
`define ENC_MAX_KPPS 4600
`define ENC_GAP_CYC ((`CLK_KHZ + `ENC_MAX_KPPS - 1) / `ENC_MAX_KPPS)
`endif

// ===== tb/pulse_source_model.sv
// Positioning controller model that drives the command pulse pins
`timescale 1ns/10ps
`default_nettype none
module pulse_source_model (
	// Clock
	input wire logic clk,
	// Command pulse pins
	output logic fwd_pin,
	output logic rev_pin
);
	logic neg_lvl = 1'b0;
	// Start with both lines at the positive logic idle level
	initial begin
		fwd_pin = 1'b0;
		rev_pin = 1'b0;
	end
	// Drive one logical level pair through the polarity for hold cycles
	task automatic put(input logic f, input logic r, input int hold);
		@(posedge clk);
		fwd_pin <= f ^ neg_lvl;
		rev_pin <= r ^ neg_lvl;
		repeat (hold - 1) @(posedge clk);
	endtask : put
	// Move both lines to the inactive level of the chosen polarity
	task automatic idle(input logic neg);
		neg_lvl = neg;
		put(1'b0, 1'b0, 3);
	endtask : idle
	// Send n command units in the given form, forward or reverse
	task automatic send(input int form, input logic rev, input int n);
		logic fw;
		fw = !rev;
		if (form == 1) begin
			put(1'b0, rev, 2); // Sign settles before the first pulse
		end
		repeat (n) begin
			if (form == 0) begin
				put(fw, rev, 2);
				put(1'b0, 1'b0, 2);
			end else if (form == 1) begin
				put(1'b1, rev, 2);
				put(1'b0, rev, 2);
			end else begin
				for (int k = 0; k < 4; k++) begin
					put(fw ? k < 2 : (k == 1 || k == 2),
						fw ? (k == 1 || k == 2) : k < 2, 2);
				end
			end
		end
		put(1'b0, 1'b0, 2);
	endtask : send
endmodule : pulse_source_model
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the servo pulse IO block
`timescale 1ns/10ps
`default_nettype none
`include "servo_io_regs.svh"
module tb
	import servo_io_pkg::*;
;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, rd;
	logic reg_wr = 1'b0, reg_rd = 1'b0;
	logic fwd_pin, rev_pin, fb_step = 1'b0, fb_ccw = 1'b0;
	motion_t cmd_out;
	logic signed [31:0] pos_err_cmd = 32'sd100, pos_err_enc = 32'sd0;
	logic signed [15:0] torque_req = 16'sh0, torque_out;
	logic [15:0] mon;
	logic settled, enc_a, enc_b, irq;
	logic [1:0] ab_prev = 2'h0;
	int error_cnt = 0, n_checks = 0;
	int step_cnt = 0, ccw_cnt = 0, fwd_cnt = 0, rev_cnt = 0;
	int gap = 1000, min_gap = 1000, s0, s1;

	// Design and command source
	servo_pulse_io #(.ENC_RES(16), .PEND_W(8)) servo_pulse_io_inst (
		.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .forward_pulse_line(fwd_pin),
		.reverse_pulse_line(rev_pin), .cmd_out(cmd_out), .fb_step(fb_step),
		.fb_ccw(fb_ccw), .pos_err_cmd(pos_err_cmd), .pos_err_enc(pos_err_enc),
		.position_settled_flag(settled), .torque_req(torque_req),
		.torque_out(torque_out), .monitor_full_scale(mon), .enc_out_a(enc_a),
		.enc_out_b(enc_b), .irq(irq));
	pulse_source_model pulse_source_model_inst (
		.clk(sys_clk), .fwd_pin(fwd_pin), .rev_pin(rev_pin));

	// Clock, 4 ns period
	initial begin
		forever #2 sys_clk = ~sys_clk;
	end

	// Count decoded steps and emitted quadrature edges by direction
	always @(posedge sys_clk) begin
		if (cmd_out.step === 1'b1) begin
			step_cnt <= step_cnt + 1;
			ccw_cnt <= ccw_cnt + int'(cmd_out.ccw === 1'b1);
		end
		ab_prev <= {enc_a, enc_b};
		gap <= gap + 1;
		// Outputs are unknown until reset, so no edge is taken before it
		if (rst_n && {enc_a, enc_b} !== ab_prev) begin
			if (gray(ab_prev) + 2'd1 == gray({enc_a, enc_b})) begin
				fwd_cnt <= fwd_cnt + 1;
			end else begin
				rev_cnt <= rev_cnt + 1;
			end
			if (gap < min_gap) begin
				min_gap <= gap;
			end
			gap <= 1;
		end
	end

	// Quadrature position, A leading B counts upward
	function automatic logic [1:0] gray(input logic [1:0] ab);
		return {ab[0], ab[1] ^ ab[0]};
	endfunction : gray

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : reg_write

	// Read data stand only in the cycle after the strobe
	task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : reg_read

	task automatic reg_chk(input logic [7:0] a, input logic [31:0] exp);
		reg_read(a, rd);
		check("register", rd, exp);
	endtask : reg_chk

	// Apply errors, then the flag follows one cycle later
	task automatic settle_chk(input int c, input int e, input logic exp);
		@(posedge sys_clk);
		pos_err_cmd <= c;
		pos_err_enc <= e;
		repeat (2) @(posedge sys_clk);
		#1 check("settled", {31'h0, settled}, {31'h0, exp});
	endtask : settle_chk

	task automatic torque_chk(input logic signed [15:0] q,
		input logic signed [15:0] exp);
		@(posedge sys_clk);
		torque_req <= q;
		repeat (2) @(posedge sys_clk);
		#1 check("torque", 32'(torque_out), 32'(exp));
	endtask : torque_chk

	// Send command units and compare step count and direction
	task automatic run_cmd(input int f, input logic rv, input int n,
		input logic sense);
		repeat (2) @(posedge sys_clk);
		s0 = step_cnt;
		s1 = ccw_cnt;
		pulse_source_model_inst.send(f, rv, n);
		repeat (4) @(posedge sys_clk);
		check("steps", 32'(step_cnt - s0), 32'(f == 2 ? 4 * n : n));
		check("ccw", 32'(ccw_cnt - s1), (!rv ^ sense) ?
			32'(f == 2 ? 4 * n : n) : 32'h0);
	endtask : run_cmd

	task automatic enc_cfg(input int mode, input int cnt, input int cpr);
		reg_write(`OFS_ENC_MODE, 32'(mode * 16));
		reg_write(`OFS_ENC_COUNT, 32'(cnt));
		reg_write(`OFS_CMD_PER_REV, 32'(cpr));
		reg_write(`OFS_RESTART, 32'h1);
	endtask : enc_cfg

	// Feed n feedback counts and compare emitted edges by direction
	task automatic run_fb(input int n, input logic ccw, input int ef,
		input int er);
		s0 = fwd_cnt;
		s1 = rev_cnt;
		repeat (n) begin
			@(posedge sys_clk);
			fb_step <= 1'b1;
			fb_ccw <= ccw;
			@(posedge sys_clk);
			fb_step <= 1'b0;
		end
		repeat (n * 60 + 20) @(posedge sys_clk);
		check("fwd edges", 32'(fwd_cnt - s0), 32'(ef));
		check("rev edges", 32'(rev_cnt - s1), 32'(er));
	endtask : run_fb

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : end_of_test

	// Watchdog
	initial begin
		repeat (40000) @(posedge sys_clk);
		error_cnt++;
		end_of_test();
	end

	// Main sequence
	initial begin
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge sys_clk);
		reg_chk(`OFS_SETTLE_RANGE, 32'h64);
		reg_chk(`OFS_ENC_COUNT, 32'hfa0);
		reg_chk(`OFS_FWD_CAP, 32'h3e8);
		reg_chk(8'h3c, 32'h0);
		reg_chk(`OFS_STATUS, 32'h2);
		check("monitor", {16'h0, mon}, 32'h3e8);
		settle_chk(100, 0, 1'b1);
		settle_chk(101, 0, 1'b0);
		$display("test reset values done");
		reg_write(`OFS_SETTLE_RANGE, 32'h5);
		reg_write(`OFS_IRQ_STATUS, 32'h7);
		reg_write(`OFS_IRQ_MASK, 32'h1);
		settle_chk(5, 0, 1'b1);
		check("irq", {31'h0, irq}, 32'h1);
		reg_write(`OFS_IRQ_MASK, 32'h0);
		#1 check("irq masked", {31'h0, irq}, 32'h0);
		reg_chk(`OFS_IRQ_STATUS, 32'h1);
		reg_write(`OFS_IRQ_STATUS, 32'h1);
		reg_chk(`OFS_IRQ_STATUS, 32'h0);
		settle_chk(-5, 0, 1'b1);
		settle_chk(-6, 0, 1'b0);
		settle_chk(6, 0, 1'b0);
		reg_write(`OFS_SETTLE_UNIT, 32'h1);
		settle_chk(0, 9, 1'b0);
		settle_chk(100, -5, 1'b1);
		$display("test settle done");
		reg_write(`OFS_IRQ_STATUS, 32'h7);
		reg_write(`OFS_FWD_CAP, 32'd200);
		reg_write(`OFS_REV_CAP, 32'd500);
		torque_chk(16'sd900, 16'sd200);
		torque_chk(-16'sd900, -16'sd500);
		torque_chk(16'sd150, 16'sd150);
		check("monitor", {16'h0, mon}, 32'd200);
		reg_chk(`OFS_IRQ_STATUS, 32'h2);
		reg_write(`OFS_FWD_CAP, 32'd0);
		torque_chk(16'sd300, 16'sd0);
		torque_chk(-16'sd300, -16'sd300);
		check("monitor", {16'h0, mon}, 32'd0);
		reg_write(`OFS_REV_CAP, 32'd2000);
		reg_chk(`OFS_REV_CAP, 32'd1000);
		torque_chk(16'sd0, 16'sd0);
		$display("test torque done");
		for (int f = 0; f < 3; f++) begin
			for (int ng = 0; ng < 2; ng++) begin
				pulse_source_model_inst.idle(ng[0]);
				reg_write(`OFS_INPUT_FORM, 32'(ng * 16 + f));
				reg_write(`OFS_ROT_SENSE, 32'(ng));
				reg_write(`OFS_RESTART, 32'h1);
				run_cmd(f, 1'b0, 3, ng[0]);
				run_cmd(f, 1'b1, 2, ng[0]);
			end
		end
		reg_write(`OFS_INPUT_FORM, 32'h0);
		reg_write(`OFS_ROT_SENSE, 32'h0);
		run_cmd(2, 1'b0, 2, 1'b1);
		pulse_source_model_inst.idle(1'b0);
		reg_write(`OFS_RESTART, 32'h1);
		run_cmd(0, 1'b0, 2, 1'b0);
		reg_write(`OFS_INPUT_FORM, 32'h3);
		reg_write(`OFS_RESTART, 32'h1);
		s0 = step_cnt;
		pulse_source_model_inst.send(0, 1'b0, 2);
		repeat (4) @(posedge sys_clk);
		check("no form", 32'(step_cnt - s0), 32'h0);
		$display("test command input done");
		reg_write(`OFS_ENC_COUNT, 32'h0);
		reg_chk(`OFS_ENC_COUNT, 32'd1);
		reg_write(`OFS_ENC_COUNT, 32'd200000);
		reg_chk(`OFS_ENC_COUNT, 32'd100000);
		enc_cfg(0, 16, 16);
		run_fb(8, 1'b0, 8, 0);
		run_fb(4, 1'b1, 0, 4);
		enc_cfg(0, 8, 16);
		run_fb(16, 1'b0, 8, 0);
		enc_cfg(1, 4, 16);
		run_fb(16, 1'b0, 4, 0);
		enc_cfg(2, 16, 8);
		run_fb(16, 1'b0, 8, 0);
		enc_cfg(3, 16, 16);
		run_fb(4, 1'b0, 0, 0);
		check("edge gap", 32'(min_gap >= `ENC_GAP_CYC), 32'h1);
		$display("test encoder output done");
		end_of_test();
	end
endmodule : tb
`default_nettype wire
